// ### verilog/cfg_guard_pkg.sv
`default_nettype none
package cfg_guard_pkg;
   // ****************************************
   // word layout
   // ****************************************
   localparam int WORD_W = 24;
   localparam int LIMIT_W = 13;
   localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;
   // security word implemented bits
   localparam logic [23:0] SEC_IMPL_MASK = 24'h008FEF;
   localparam logic [23:0] LIMIT_IMPL_MASK = 24'h001FFF;
   localparam logic [23:0] SIGN_IMPL_MASK = 24'h008000;
   localparam int ALT_VT_BIT = 15;
   localparam int CSEG_LVL_LO = 9;
   localparam int CSEG_WL_BIT = 8;
   localparam int GSEG_LVL_LO = 6;
   localparam int GSEG_WL_BIT = 5;
   localparam int BOOT_ABS_BIT = 3;
   localparam int BOOT_LVL_LO = 1;
   localparam int BOOT_WL_BIT = 0;
   // ****************************************
   // register offsets (byte address, four per word)
   // ****************************************
   localparam logic [3:0] OFS_SEC = 4'h0;
   localparam logic [3:0] OFS_LIMIT = 4'h4;
   localparam logic [3:0] OFS_SIGN = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   // ****************************************
   // protection levels and load states
   // ****************************************
   typedef enum logic [1:0] {
      LVL_NONE = 2'h0,
      LVL_STANDARD = 2'h1,
      LVL_ENHANCED = 2'h2,
      LVL_HIGH = 2'h3
   } level_t;
   typedef enum logic [3:0] {
      ST_FETCH = 4'h1,
      ST_WAIT = 4'h2,
      ST_LATCH = 4'h4,
      ST_RUN = 4'h8
   } load_state_t;
   localparam logic [1:0] LAST_WORD_IDX = 2'h2;
endpackage
`default_nettype wire

// ### verilog/level_decode.sv
`timescale 1ns/1ps
`default_nettype none
// decodes one segment's protection field; 3-bit config field or 2-bit field
module level_decode #(
   parameter bit WIDE = 1'b0
) (
   // field
   input wire logic [2:0] field,
   // level
   output cfg_guard_pkg::level_t level
);
   always_comb begin
      if (WIDE) begin
         if (field == 3'h7) begin
            level = cfg_guard_pkg::LVL_NONE;
         end else if (field == 3'h6) begin
            level = cfg_guard_pkg::LVL_STANDARD;
         end else if (field[2]) begin
            level = cfg_guard_pkg::LVL_ENHANCED;
         end else begin
            level = cfg_guard_pkg::LVL_HIGH;
         end
      end else begin
         if (field[1:0] == 2'h3) begin
            level = cfg_guard_pkg::LVL_NONE;
         end else if (field[1:0] == 2'h2) begin
            level = cfg_guard_pkg::LVL_STANDARD;
         end else begin
            level = cfg_guard_pkg::LVL_HIGH;
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/code_flash_security_config.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - words are 24 bits, unimplemented bits read one
// - bit 15 set disables alternate vector table
// - config level field decodes 111/110/10x/0xx
// - config write lock zero blocks config writes
// - general level field decodes 11/10/0x
// - general write lock zero protects user memory
// - boot absent flag one means no boot segment
// - boot level field decodes 11/10/0x
// - boot write lock zero protects boot memory
// - limit field marks first general segment page
// - programmed limit refuses further writes, no start
// - implemented bits program once, only clear
// - reset copies flash words into shadow registers
// - every reset reloads shadow values
module code_flash_security_config (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // flash configuration word fetch
   output logic [1:0] FETCH_IDX,
   output logic FETCH_REQ,
   input wire logic FETCH_ACK,
   input wire logic [23:0] FETCH_DATA,
   // register port
   input wire logic [3:0] REG_ADDR,
   input wire logic [23:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [23:0] REG_RDATA,
   // flash program request for the limit word
   input wire logic LIMIT_PROG_REQ,
   output logic WRITE_START,
   // protection outputs
   output logic CONFIG_READY,
   output logic ALT_VECTOR_TABLE_OFF,
   output cfg_guard_pkg::level_t CONFIG_SEGMENT_PROTECT_LEVEL,
   output logic CONFIG_SEGMENT_WRITE_LOCK,
   output cfg_guard_pkg::level_t GENERAL_SEGMENT_PROTECT_LEVEL,
   output logic GENERAL_SEGMENT_WRITE_LOCK,
   output logic BOOT_SEGMENT_ABSENT,
   output cfg_guard_pkg::level_t BOOT_SEGMENT_PROTECT_LEVEL,
   output logic BOOT_SEGMENT_WRITE_LOCK,
   output logic [12:0] BOOT_PAGE_LIMIT
);
   // ****************************************
   // shadow load sequence
   // ****************************************
   cfg_guard_pkg::load_state_t state, next_state;
   logic [1:0] idx, next_idx;
   logic [23:0] sec, next_sec;
   logic [23:0] lim, next_lim;
   logic [23:0] sign, next_sign;
   logic [23:0] cap, next_cap;

   // keep implemented bits only; all others forced to one
   function automatic logic [23:0] fill_ones(input logic [23:0] v, input logic [23:0] m);
      fill_ones = v | ~m;
   endfunction

   // SYS_RST is every kind of device reset, so the reload always repeats
   always_comb begin
      next_state = state;
      next_idx = idx;
      next_sec = sec;
      next_lim = lim;
      next_sign = sign;
      next_cap = cap;
      case (state)
         cfg_guard_pkg::ST_FETCH: begin
            next_state = cfg_guard_pkg::ST_WAIT;
         end
         cfg_guard_pkg::ST_WAIT: begin
            if (FETCH_ACK) begin
               next_cap = FETCH_DATA;
               next_state = cfg_guard_pkg::ST_LATCH;
            end
         end
         cfg_guard_pkg::ST_LATCH: begin
            if (idx == 2'h0) begin
               next_sec = fill_ones(cap, cfg_guard_pkg::SEC_IMPL_MASK);
            end else if (idx == 2'h1) begin
               next_lim = fill_ones(cap, cfg_guard_pkg::LIMIT_IMPL_MASK);
            end else begin
               next_sign = fill_ones(cap, cfg_guard_pkg::SIGN_IMPL_MASK);
            end
            if (idx == cfg_guard_pkg::LAST_WORD_IDX) begin
               next_state = cfg_guard_pkg::ST_RUN;
            end else begin
               next_idx = idx + 2'h1;
               next_state = cfg_guard_pkg::ST_FETCH;
            end
         end
         cfg_guard_pkg::ST_RUN: begin
            next_state = cfg_guard_pkg::ST_RUN;
         end
         default: begin
            next_state = cfg_guard_pkg::ST_FETCH;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         state <= cfg_guard_pkg::ST_FETCH;
         idx <= 2'h0;
         sec <= cfg_guard_pkg::ERASED_WORD;
         lim <= cfg_guard_pkg::ERASED_WORD;
         sign <= cfg_guard_pkg::ERASED_WORD;
         cap <= cfg_guard_pkg::ERASED_WORD;
      end else begin
         state <= next_state;
         idx <= next_idx;
         sec <= next_sec;
         lim <= next_lim;
         sign <= next_sign;
         cap <= next_cap;
      end
   end

   assign FETCH_IDX = idx;
   assign FETCH_REQ = (state == cfg_guard_pkg::ST_FETCH);
   assign CONFIG_READY = (state == cfg_guard_pkg::ST_RUN);

   // ****************************************
   // protection decode
   // ****************************************
   // shadows change only during the reset load, so these hold steady after
   assign ALT_VECTOR_TABLE_OFF = sec[cfg_guard_pkg::ALT_VT_BIT];
   assign CONFIG_SEGMENT_WRITE_LOCK = ~sec[cfg_guard_pkg::CSEG_WL_BIT];
   assign GENERAL_SEGMENT_WRITE_LOCK = ~sec[cfg_guard_pkg::GSEG_WL_BIT];
   assign BOOT_SEGMENT_ABSENT = sec[cfg_guard_pkg::BOOT_ABS_BIT];
   assign BOOT_SEGMENT_WRITE_LOCK = ~sec[cfg_guard_pkg::BOOT_WL_BIT];
   // stored inverted, page address is the complement
   assign BOOT_PAGE_LIMIT = ~lim[12:0];

   level_decode #(.WIDE(1'b1)) u_cseg (
      .field(sec[cfg_guard_pkg::CSEG_LVL_LO +: 3]),
      .level(CONFIG_SEGMENT_PROTECT_LEVEL)
   );
   level_decode #(.WIDE(1'b0)) u_gseg (
      .field({1'b1, sec[cfg_guard_pkg::GSEG_LVL_LO +: 2]}),
      .level(GENERAL_SEGMENT_PROTECT_LEVEL)
   );
   level_decode #(.WIDE(1'b0)) u_bseg (
      .field({1'b1, sec[cfg_guard_pkg::BOOT_LVL_LO +: 2]}),
      .level(BOOT_SEGMENT_PROTECT_LEVEL)
   );

   // ****************************************
   // limit program gate and register port
   // ****************************************
   logic limit_erased;
   logic next_start, start;
   logic [23:0] next_rdata, rdata;
   assign limit_erased = (lim[12:0] == 13'h1FFF);

   // shadow words are not writable; bits only clear by flash programming
   always_comb begin
      next_start = 1'b0;
      if (LIMIT_PROG_REQ && CONFIG_READY && limit_erased) begin
         next_start = 1'b1;
      end
      next_rdata = 24'h000000;
      if (REG_RD) begin
         if (REG_ADDR == cfg_guard_pkg::OFS_SEC) begin
            next_rdata = sec;
         end else if (REG_ADDR == cfg_guard_pkg::OFS_LIMIT) begin
            next_rdata = lim;
         end else if (REG_ADDR == cfg_guard_pkg::OFS_SIGN) begin
            next_rdata = sign;
         end else if (REG_ADDR == cfg_guard_pkg::OFS_STATUS) begin
            next_rdata = {22'h000000, limit_erased, CONFIG_READY};
         end else begin
            next_rdata = 24'h000000;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         start <= 1'b0;
         rdata <= 24'h000000;
      end else begin
         start <= next_start;
         rdata <= next_rdata;
      end
   end

   assign WRITE_START = start;
   assign REG_RDATA = rdata;

   // ****************************************
   // checks
   // ****************************************
   // segment checks look one edge past the latch of their word: the shadow
   // has just taken the captured word and cap still holds it unchanged
   sequence load_done_s;
      state == cfg_guard_pkg::ST_RUN;
   endsequence

   sequence fetch_s;
      state == cfg_guard_pkg::ST_FETCH;
   endsequence

   sequence wait_ack_s;
      state == cfg_guard_pkg::ST_WAIT && FETCH_ACK;
   endsequence

   sequence sec_latch_s;
      state == cfg_guard_pkg::ST_LATCH && idx == 2'h0;
   endsequence

   sequence lim_latch_s;
      state == cfg_guard_pkg::ST_LATCH && idx == 2'h1;
   endsequence

   sequence last_latch_s;
      state == cfg_guard_pkg::ST_LATCH && idx == cfg_guard_pkg::LAST_WORD_IDX;
   endsequence

   // ****************************************
   // load sequence checks
   // ****************************************
   fetch_step_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      fetch_s |=> state == cfg_guard_pkg::ST_WAIT)
      else $error("fetch did not move to wait");
   wait_ack_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      wait_ack_s |=> state == cfg_guard_pkg::ST_LATCH)
      else $error("acknowledged word not latched");
   load_order_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s |=> FETCH_REQ && FETCH_IDX == 2'h1)
      else $error("limit word not fetched after security word");
   ready_load_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      last_latch_s |=> CONFIG_READY)
      else $error("ready missing after last word");
   stable_decode_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      load_done_s |=> $stable(sec) && $stable(lim))
      else $error("shadow changed after load");
   reload_a: assert property (@(posedge SYS_CLK)
      SYS_RST |=> state == cfg_guard_pkg::ST_FETCH)
      else $error("reset did not restart load");

   // ****************************************
   // decode checks
   // ****************************************
   vector_off_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s |=> ALT_VECTOR_TABLE_OFF == cap[cfg_guard_pkg::ALT_VT_BIT])
      else $error("vector table flag mismatch");
   cseg_write_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s |=> CONFIG_SEGMENT_WRITE_LOCK == !cap[cfg_guard_pkg::CSEG_WL_BIT])
      else $error("config lock wrong");
   gen_lock_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s |=> GENERAL_SEGMENT_WRITE_LOCK == !cap[cfg_guard_pkg::GSEG_WL_BIT])
      else $error("general lock wrong");
   boot_lock_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s |=> BOOT_SEGMENT_WRITE_LOCK == !cap[cfg_guard_pkg::BOOT_WL_BIT])
      else $error("boot lock wrong");
   boot_absent_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s |=> BOOT_SEGMENT_ABSENT == cap[cfg_guard_pkg::BOOT_ABS_BIT])
      else $error("boot absent flag wrong");
   cseg_none_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 cap[cfg_guard_pkg::CSEG_LVL_LO +: 3] == 3'h7
      |=> CONFIG_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_NONE)
      else $error("config level none wrong");
   cseg_enh_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 cap[cfg_guard_pkg::CSEG_LVL_LO + 1 +: 2] == 2'h2
      |=> CONFIG_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_ENHANCED)
      else $error("config level enhanced wrong");
   cseg_high_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 !cap[cfg_guard_pkg::CSEG_LVL_LO + 2]
      |=> CONFIG_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_HIGH)
      else $error("config level high wrong");
   gseg_std_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 cap[cfg_guard_pkg::GSEG_LVL_LO +: 2] == 2'h2
      |=> GENERAL_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_STANDARD)
      else $error("general level standard wrong");
   gseg_high_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 !cap[cfg_guard_pkg::GSEG_LVL_LO + 1]
      |=> GENERAL_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_HIGH)
      else $error("general level high wrong");
   bseg_std_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 cap[cfg_guard_pkg::BOOT_LVL_LO +: 2] == 2'h2
      |=> BOOT_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_STANDARD)
      else $error("boot level standard wrong");
   bseg_high_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      sec_latch_s ##0 !cap[cfg_guard_pkg::BOOT_LVL_LO + 1]
      |=> BOOT_SEGMENT_PROTECT_LEVEL == cfg_guard_pkg::LVL_HIGH)
      else $error("boot level high wrong");
   boot_limit_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      lim_latch_s |=> BOOT_PAGE_LIMIT == ~cap[12:0])
      else $error("limit not inverted");

   // ****************************************
   // register port and program gate checks
   // ****************************************
   upper_ones_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      $past(REG_RD) && $past(REG_ADDR) != cfg_guard_pkg::OFS_STATUS
      && $past(REG_ADDR[1:0]) == 2'h0 |-> REG_RDATA[23:16] == 8'hFF)
      else $error("upper bits not one");
   write_ignored_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      CONFIG_READY && REG_WR && (REG_WDATA & sec) != sec
      |=> $stable(sec) && $stable(lim) && $stable(sign))
      else $error("bus write changed a shadow word");
   limit_once_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      WRITE_START |-> $past(limit_erased) && $past(LIMIT_PROG_REQ) && $past(CONFIG_READY))
      else $error("write start with programmed limit");
   start_follows_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (LIMIT_PROG_REQ && CONFIG_READY && limit_erased) |=> WRITE_START)
      else $error("erased limit program not started");
endmodule
`default_nettype wire

// ### dv/test_code_flash_security_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_code_flash_security_config;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [1:0] FETCH_IDX;
   logic FETCH_REQ;
   logic FETCH_ACK = 1'b0;
   logic [23:0] FETCH_DATA = 24'h000000;
   logic [3:0] REG_ADDR = 4'h0;
   logic [23:0] REG_WDATA = 24'h000000;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [23:0] REG_RDATA;
   logic LIMIT_PROG_REQ = 1'b0;
   logic WRITE_START, CONFIG_READY, ALT_VECTOR_TABLE_OFF;
   logic CONFIG_SEGMENT_WRITE_LOCK, GENERAL_SEGMENT_WRITE_LOCK;
   logic BOOT_SEGMENT_ABSENT, BOOT_SEGMENT_WRITE_LOCK;
   cfg_guard_pkg::level_t CONFIG_SEGMENT_PROTECT_LEVEL, GENERAL_SEGMENT_PROTECT_LEVEL;
   cfg_guard_pkg::level_t BOOT_SEGMENT_PROTECT_LEVEL;
   logic [12:0] BOOT_PAGE_LIMIT;
   int n_mismatch = 0;
   int checks_done = 0;

   code_flash_security_config code_flash_security_config_inst (
      .SYS_CLK(SYS_CLK),
      .SYS_RST(SYS_RST),
      .FETCH_IDX(FETCH_IDX),
      .FETCH_REQ(FETCH_REQ),
      .FETCH_ACK(FETCH_ACK),
      .FETCH_DATA(FETCH_DATA),
      .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR),
      .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA),
      .LIMIT_PROG_REQ(LIMIT_PROG_REQ),
      .WRITE_START(WRITE_START),
      .CONFIG_READY(CONFIG_READY),
      .ALT_VECTOR_TABLE_OFF(ALT_VECTOR_TABLE_OFF),
      .CONFIG_SEGMENT_PROTECT_LEVEL(CONFIG_SEGMENT_PROTECT_LEVEL),
      .CONFIG_SEGMENT_WRITE_LOCK(CONFIG_SEGMENT_WRITE_LOCK),
      .GENERAL_SEGMENT_PROTECT_LEVEL(GENERAL_SEGMENT_PROTECT_LEVEL),
      .GENERAL_SEGMENT_WRITE_LOCK(GENERAL_SEGMENT_WRITE_LOCK),
      .BOOT_SEGMENT_ABSENT(BOOT_SEGMENT_ABSENT),
      .BOOT_SEGMENT_PROTECT_LEVEL(BOOT_SEGMENT_PROTECT_LEVEL),
      .BOOT_SEGMENT_WRITE_LOCK(BOOT_SEGMENT_WRITE_LOCK),
      .BOOT_PAGE_LIMIT(BOOT_PAGE_LIMIT)
   );

   initial begin
      forever #4 SYS_CLK = ~SYS_CLK;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   function automatic logic [1:0] lvl3(input logic [2:0] f);
      casez (f)
         3'b111: return 2'h0;
         3'b110: return 2'h1;
         3'b10?: return 2'h2;
         default: return 2'h3;
      endcase
   endfunction

   function automatic logic [1:0] lvl2(input logic [1:0] f);
      return (f == 2'b11) ? 2'h0 : (f == 2'b10) ? 2'h1 : 2'h3;
   endfunction

   // one word handed over: ack one cycle after the request cycle
   task automatic fetch(input logic [1:0] idx, input logic [23:0] w);
      int n;
      n = 0;
      while (FETCH_REQ !== 1'b1 && n < 50) begin
         @(posedge SYS_CLK);
         #1;
         n++;
      end
      chk("fetch_req", {23'h0, FETCH_REQ}, 24'h1);
      chk("fetch_idx", {22'h0, FETCH_IDX}, {22'h0, idx});
      @(posedge SYS_CLK);
      FETCH_ACK <= 1'b1;
      FETCH_DATA <= w;
      @(posedge SYS_CLK);
      FETCH_ACK <= 1'b0;
      FETCH_DATA <= ~w;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [23:0] exp, input string name);
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1;
      chk(name, REG_RDATA, exp);
   endtask

   // ****************************************
   // watchdog and main sequence
   // ****************************************
   initial begin
      #(8 * 20000);
      n_mismatch++;
      results();
   end

   initial begin
      logic [2:0] b;
      logic [23:0] sec, lim, sgn;
      int n;
      for (int i = 0; i < 8; i++) begin
         b = i[2:0];
         sec = {8'h00, b[0], 3'b000, b, b[0], b[1:0], b[1], 1'b0, b[2], b[2:1], ~b[0]};
         lim = b[0] ? 24'hFFFFFF : {11'h000, 13'h1FBF ^ {10'h000, b}};
         // signature bit 15 kept low; the 24'h007FFF word sets unimplemented bits 14:0 high
         sgn = b[1] ? 24'h000000 : 24'h007FFF;
         // every reset reloads, so each later pass restarts with a fresh reset
         if (i > 0) begin
            @(posedge SYS_CLK);
            SYS_RST <= 1'b1;
         end
         repeat (2) @(posedge SYS_CLK);
         SYS_RST <= 1'b0;
         #1;
         chk("ready_in_reset", {23'h0, CONFIG_READY}, 24'h0);
         fetch(2'h0, sec);
         fetch(2'h1, lim);
         fetch(2'h2, sgn);
         n = 0;
         while (CONFIG_READY !== 1'b1 && n < 20) begin
            @(posedge SYS_CLK);
            #1;
            n++;
         end
         chk("ready", {23'h0, CONFIG_READY}, 24'h1);
         chk("alt_vt", {23'h0, ALT_VECTOR_TABLE_OFF}, {23'h0, b[0]});
         chk("cfg_lvl", {22'h0, CONFIG_SEGMENT_PROTECT_LEVEL}, {22'h0, lvl3(b)});
         chk("cfg_wl", {23'h0, CONFIG_SEGMENT_WRITE_LOCK}, {23'h0, ~b[0]});
         chk("gen_lvl", {22'h0, GENERAL_SEGMENT_PROTECT_LEVEL}, {22'h0, lvl2(b[1:0])});
         chk("gen_wl", {23'h0, GENERAL_SEGMENT_WRITE_LOCK}, {23'h0, ~b[1]});
         chk("boot_abs", {23'h0, BOOT_SEGMENT_ABSENT}, {23'h0, b[2]});
         chk("boot_lvl", {22'h0, BOOT_SEGMENT_PROTECT_LEVEL}, {22'h0, lvl2(b[2:1])});
         chk("boot_wl", {23'h0, BOOT_SEGMENT_WRITE_LOCK}, {23'h0, b[0]});
         chk("page_lim", {11'h0, BOOT_PAGE_LIMIT}, {11'h0, ~lim[12:0]});
         // words are program-once from software's view: a bus write must not land
         @(posedge SYS_CLK);
         REG_WR <= 1'b1;
         REG_ADDR <= cfg_guard_pkg::OFS_SEC;
         REG_WDATA <= 24'h000000;
         @(posedge SYS_CLK);
         REG_WR <= 1'b0;
         rd(cfg_guard_pkg::OFS_SEC, sec | 24'hFF7010, "sec_word");
         rd(cfg_guard_pkg::OFS_LIMIT, lim | 24'hFFE000, "limit_word");
         rd(cfg_guard_pkg::OFS_SIGN, sgn | 24'hFF7FFF, "sign_word");
         rd(cfg_guard_pkg::OFS_STATUS, {22'h0, b[0], 1'b1}, "status");
         rd(4'h2, 24'h000000, "unmapped");
         @(posedge SYS_CLK);
         LIMIT_PROG_REQ <= 1'b1;
         @(posedge SYS_CLK);
         LIMIT_PROG_REQ <= 1'b0;
         #1;
         chk("wr_start", {23'h0, WRITE_START}, {23'h0, b[0]});
         @(posedge SYS_CLK);
         #1;
         chk("wr_start_end", {23'h0, WRITE_START}, 24'h0);
         chk("cfg_lvl_hold", {22'h0, CONFIG_SEGMENT_PROTECT_LEVEL}, {22'h0, lvl3(b)});
      end
      results();
   end
endmodule
`default_nettype wire
